// ==== rtl/cam_pkg.sv ====
`default_nettype none
package cam_pkg;
    // Search behaviour of the lookup array
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_MULTI = 2'h1,
        MODE_FAST = 2'h3
    } match_mode_e;

    // Default geometry
    localparam int DEF_WIDTH = 32;
    localparam int DEF_ENTRY_COUNT = 32;

    // Write lengths in clock cycles
    localparam logic [1:0] WR_CYC_PLAIN = 2'h2;
    localparam logic [1:0] WR_CYC_MASK = 2'h3;
    localparam logic [1:0] DEL_CYC = 2'h2;

    // Controller register byte offsets
    localparam logic [4:0] OFS_CMD = 5'h00;
    localparam logic [4:0] OFS_KEY = 5'h04;
    localparam logic [4:0] OFS_MASK = 5'h08;
    localparam logic [4:0] OFS_INDEX = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_MATCH = 5'h14;

    // Command register bits
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_ERASE_BIT = 1;
    localparam int CMD_MASK_EN_BIT = 2;
    localparam int CMD_SEARCH_BIT = 3;
    localparam int CMD_NEXT_BIT = 4;

    // Status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_HIT_BIT = 1;
    localparam int ST_COUNT_LSB = 8;
    localparam int ST_INDEX_LSB = 16;

    // Reset values
    localparam logic [31:0] KEY_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// ==== rtl/cam_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface cam_if #(
    parameter int WIDTH = 32,
    parameter int ENTRY_COUNT = 32
);
    localparam int IDX_W = $clog2(ENTRY_COUNT);
    localparam int CNT_W = $clog2(ENTRY_COUNT + 1);

    // Host to array
    logic [WIDTH-1:0] key;
    logic [WIDTH-1:0] mask;
    logic mask_en;
    logic erase;
    logic wren;
    logic [IDX_W-1:0] wr_idx;
    logic first_req;
    logic next_req;
    logic in_clk_en;
    // Array to host
    logic hit;
    logic [IDX_W-1:0] match_idx;
    logic [ENTRY_COUNT-1:0] match_vec;
    logic [CNT_W-1:0] hit_count;
    logic rd_busy;
    logic wr_busy;

    modport host (
        output key, mask, mask_en, erase, wren, wr_idx, first_req, next_req, in_clk_en,
        input hit, match_idx, match_vec, hit_count, rd_busy, wr_busy
    );
    modport dev (
        input key, mask, mask_en, erase, wren, wr_idx, first_req, next_req, in_clk_en,
        output hit, match_idx, match_vec, hit_count, rd_busy, wr_busy
    );
endinterface
`default_nettype wire

// ==== rtl/cam_array.sv ====
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Plain write lasts two held cycles
// - Masked write lasts three held cycles
// - Host holds request, index, key throughout write
// - Mask bit one means don't-care
// - Mask stored only when mask enable set
// - Erase plus write for two cycles deletes
// - Delete ignores key, mask, mask enable
// - Write request low during searches
// - Unregistered key held two full cycles
// - Single mode result after one cycle
// - Hit sets flag, index and vector bit
// - Single mode count is zero or one
// - Index width is ceil log2 entries
// - Match vector has one bit per entry
// - First request restarts search, lowest match
// - Next request steps to next match
// - Optional output register stage with enable
// - Separate async clear for the output register stage
// - Hold inputs while busy outputs high
// - Priority encoder derives index from vector
// - Hit and count from vector logic
// - Data one with mask one never matches
// - First lowest, next ascending indices
module cam_array
    import cam_pkg::*;
#(
    parameter int WIDTH = DEF_WIDTH,
    parameter int ENTRY_COUNT = DEF_ENTRY_COUNT,
    parameter match_mode_e MATCH_MODE = MODE_SINGLE,
    parameter bit OUT_REG = 1'b0
) (
    // Host side
    cam_if.dev link,
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    // Output stage controls
    input wire logic out_rst_n,
    input wire logic out_clk_en
);
    // Index and count widths; the count needs room for a full table
    localparam int IDX_W = $clog2(ENTRY_COUNT);
    localparam int CNT_W = $clog2(ENTRY_COUNT + 1);
    localparam bit MULTI = (MATCH_MODE == MODE_MULTI);
    localparam bit SINGLE = (MATCH_MODE == MODE_SINGLE);

    // Lowest set bit at or above start; found flag on top
    function automatic logic [IDX_W:0] first_from(input logic [ENTRY_COUNT-1:0] vec, input int start);
        logic [IDX_W:0] res;
        res = '0;
        for (int i = ENTRY_COUNT - 1; i >= 0; i--) begin
            if (vec[i] && i >= start) begin
                res = {1'b1, IDX_W'(i)};
            end
        end
        return res;
    endfunction

    // Number of set bits
    function automatic logic [CNT_W-1:0] ones(input logic [ENTRY_COUNT-1:0] vec);
        logic [CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < ENTRY_COUNT; i++) begin
            n = n + CNT_W'(vec[i]);
        end
        return n;
    endfunction

    // Stored pattern and don't-care planes
    logic [WIDTH-1:0] data_reg [ENTRY_COUNT];
    logic [WIDTH-1:0] dc_reg [ENTRY_COUNT];

    // Write counter and multiple-mode compare state
    logic [1:0] wr_cnt_reg;
    logic [WIDTH-1:0] key_reg;
    logic pend_reg;

    // Search results; a step moves only index and flag
    logic [ENTRY_COUNT-1:0] vec_reg;
    logic [IDX_W-1:0] idx_reg;
    logic found_reg;
    logic [CNT_W-1:0] count_reg;

    // Write sequencing
    wire [1:0] wr_len = link.erase ? DEL_CYC : (link.mask_en ? WR_CYC_MASK : WR_CYC_PLAIN);
    wire wr_last = link.wren && (wr_cnt_reg == wr_len - 2'h1);
    wire commit = link.in_clk_en && wr_last;
    wire [1:0] wr_cnt_next = !link.wren ? 2'h0 : (wr_last ? 2'h0 : wr_cnt_reg + 2'h1);
    // Delete stores the never-match pattern, key and mask unused
    wire [WIDTH-1:0] data_in = link.erase ? '1 : link.key;
    wire [WIDTH-1:0] dc_in = link.erase ? '1 : (link.mask_en ? link.mask : '0);

    // Write counter; holding wren past the last cycle starts another write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_cnt_reg <= 2'h0;
        end else if (link.in_clk_en) begin
            wr_cnt_reg <= wr_cnt_next;
        end
    end

    // Storage; reset leaves every entry at never-match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ENTRY_COUNT; i++) begin
                data_reg[i] <= '1;
                dc_reg[i] <= '1;
            end
        end else if (commit) begin
            data_reg[link.wr_idx] <= data_in;
            dc_reg[link.wr_idx] <= dc_in;
        end
    end

    // Search launch; a search is never taken while wren is high
    wire search_go = link.in_clk_en && !link.wren && (SINGLE || link.first_req);
    wire load_res = MULTI ? (link.in_clk_en && pend_reg) : search_go;
    wire step = !SINGLE && link.in_clk_en && link.next_req && !pend_reg && !search_go;
    wire [WIDTH-1:0] cmp_key = MULTI ? key_reg : link.key;

    // Parallel compare of every entry
    logic [ENTRY_COUNT-1:0] live_vec;
    always_comb begin
        for (int i = 0; i < ENTRY_COUNT; i++) begin
            live_vec[i] = ~|((data_reg[i] ^ cmp_key) & ~dc_reg[i])
                && ~|(data_reg[i] & dc_reg[i]);
        end
    end

    // Encoders outside the storage planes
    wire [IDX_W:0] first_hit = first_from(live_vec, 0);
    wire [IDX_W:0] next_hit = first_from(vec_reg, int'(idx_reg) + 1);
    wire [CNT_W-1:0] live_count = SINGLE ? CNT_W'(first_hit[IDX_W]) : ones(live_vec);

    // Multiple mode spends a second cycle on the compare
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            key_reg <= '0;
        end else if (link.in_clk_en) begin
            pend_reg <= MULTI && search_go;
            if (search_go) begin
                key_reg <= link.key;
            end
        end
    end

    // Result registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_reg <= '0;
            idx_reg <= '0;
            found_reg <= 1'b0;
            count_reg <= '0;
        end else if (load_res) begin
            vec_reg <= live_vec;
            idx_reg <= first_hit[IDX_W-1:0];
            found_reg <= first_hit[IDX_W];
            count_reg <= live_count;
        end else if (step) begin
            // Past the last match the flag drops and the index stays
            idx_reg <= next_hit[IDX_W] ? next_hit[IDX_W-1:0] : idx_reg;
            found_reg <= next_hit[IDX_W];
        end
    end

    // Optional output stage on its own clear and enable
    generate
        if (OUT_REG) begin : g_out
            logic [ENTRY_COUNT-1:0] vec_o_reg;
            logic [IDX_W-1:0] idx_o_reg;
            logic found_o_reg;
            logic [CNT_W-1:0] count_o_reg;
            always_ff @(posedge clk or negedge out_rst_n) begin
                if (!out_rst_n) begin
                    vec_o_reg <= '0;
                    idx_o_reg <= '0;
                    found_o_reg <= 1'b0;
                    count_o_reg <= '0;
                end else if (out_clk_en) begin
                    vec_o_reg <= vec_reg;
                    idx_o_reg <= idx_reg;
                    found_o_reg <= found_reg;
                    count_o_reg <= count_reg;
                end
            end
            assign link.match_vec = vec_o_reg;
            assign link.match_idx = idx_o_reg;
            assign link.hit = found_o_reg;
            assign link.hit_count = count_o_reg;
        end else begin : g_direct
            assign link.match_vec = vec_reg;
            assign link.match_idx = idx_reg;
            assign link.hit = found_reg;
            assign link.hit_count = count_reg;
        end
    endgenerate

    // Busy flags tell the host to hold its inputs
    // Write busy is combinational so the host can leave in the last cycle
    assign link.wr_busy = link.wren && !wr_last;
    assign link.rd_busy = pend_reg;
endmodule
`default_nettype wire

// ==== rtl/cam_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module cam_host
    import cam_pkg::*;
#(
    parameter int WIDTH = DEF_WIDTH,
    parameter int ENTRY_COUNT = DEF_ENTRY_COUNT,
    parameter match_mode_e MATCH_MODE = MODE_SINGLE
) (
    // Array side
    cam_if.host link,
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    localparam int IDX_W = $clog2(ENTRY_COUNT);
    localparam int CNT_W = $clog2(ENTRY_COUNT + 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WRITE = 2'h1,
        ST_SEARCH = 2'h3,
        ST_SETTLE = 2'h2
    } host_state_e;

    // Byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    host_state_e state_reg, state_next;
    logic [31:0] key_reg, mask_reg, index_reg, readdata_reg;
    logic erase_reg, mask_en_reg, next_reg, ack_reg;

    // Bus decode; command writes stall while an operation runs
    wire busy = (state_reg != ST_IDLE);
    wire sel_cmd = (avs_address == OFS_CMD);
    wire cmd_stall = avs_write && sel_cmd && busy;
    wire take = (avs_read || avs_write) && !ack_reg && !cmd_stall;
    wire wr_take = take && avs_write;
    wire cmd_go = wr_take && sel_cmd && avs_byteenable[0];
    wire go_write = cmd_go && avs_writedata[CMD_WRITE_BIT];
    wire go_search = cmd_go && !avs_writedata[CMD_WRITE_BIT]
        && (avs_writedata[CMD_SEARCH_BIT] || avs_writedata[CMD_NEXT_BIT]);

    // Status word
    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[ST_BUSY_BIT] = busy;
        status_word[ST_HIT_BIT] = link.hit;
        status_word[ST_COUNT_LSB +: CNT_W] = link.hit_count;
        status_word[ST_INDEX_LSB +: IDX_W] = link.match_idx;
    end

    // Read mux; unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            OFS_KEY: rd_mux = key_reg;
            OFS_MASK: rd_mux = mask_reg;
            OFS_INDEX: rd_mux = index_reg;
            OFS_STATUS: rd_mux = status_word;
            OFS_MATCH: rd_mux = 32'(link.match_vec);
            default: rd_mux = '0;
        endcase
    end

    // Sequencer: a write holds every input until wr_busy drops
    always_comb begin
        case (state_reg)
            ST_IDLE: state_next = go_write ? ST_WRITE : (go_search ? ST_SEARCH : ST_IDLE);
            ST_WRITE: state_next = link.wr_busy ? ST_WRITE : ST_IDLE;
            ST_SEARCH: state_next = ST_SETTLE;
            ST_SETTLE: state_next = link.rd_busy ? ST_SETTLE : ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            ack_reg <= 1'b0;
            readdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            ack_reg <= take;
            readdata_reg <= (take && avs_read) ? rd_mux : readdata_reg;
        end
    end

    // Software registers; key and index frozen while busy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_reg <= KEY_RESET;
            mask_reg <= MASK_RESET;
            index_reg <= '0;
            erase_reg <= 1'b0;
            mask_en_reg <= 1'b0;
            next_reg <= 1'b0;
        end else if (wr_take && !busy) begin
            if (avs_address == OFS_KEY) key_reg <= merge(key_reg, avs_writedata, avs_byteenable);
            if (avs_address == OFS_MASK) mask_reg <= merge(mask_reg, avs_writedata, avs_byteenable);
            if (avs_address == OFS_INDEX) index_reg <= merge(index_reg, avs_writedata, avs_byteenable);
            if (cmd_go) begin
                erase_reg <= avs_writedata[CMD_ERASE_BIT];
                mask_en_reg <= avs_writedata[CMD_MASK_EN_BIT];
                next_reg <= avs_writedata[CMD_NEXT_BIT] && !avs_writedata[CMD_SEARCH_BIT];
            end
        end
    end

    // Array drive
    assign link.key = key_reg[WIDTH-1:0];
    assign link.mask = mask_reg[WIDTH-1:0];
    assign link.wr_idx = index_reg[IDX_W-1:0];
    assign link.wren = (state_reg == ST_WRITE);
    assign link.erase = (state_reg == ST_WRITE) && erase_reg;
    assign link.mask_en = (state_reg == ST_WRITE) && mask_en_reg;
    assign link.first_req = (state_reg == ST_SEARCH) && !next_reg && (MATCH_MODE != MODE_SINGLE);
    assign link.next_req = (state_reg == ST_SEARCH) && next_reg && (MATCH_MODE != MODE_SINGLE);
    assign link.in_clk_en = 1'b1;

    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
endmodule
`default_nettype wire

// ==== test/cam_link_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module cam_link_props #(
    parameter int WIDTH = 32,
    parameter int ENTRY_COUNT = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host to array
    input wire logic [WIDTH-1:0] key,
    input wire logic mask_en,
    input wire logic erase,
    input wire logic wren,
    input wire logic [$clog2(ENTRY_COUNT)-1:0] wr_idx,
    input wire logic first_req,
    input wire logic next_req,
    // Array to host
    input wire logic hit,
    input wire logic [$clog2(ENTRY_COUNT)-1:0] match_idx,
    input wire logic [ENTRY_COUNT-1:0] match_vec,
    input wire logic [$clog2(ENTRY_COUNT+1)-1:0] hit_count,
    input wire logic rd_busy,
    input wire logic wr_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Busy drops in the last write cycle
    sequence plain_walk;
        wr_busy ##1 !wr_busy;
    endsequence
    sequence mask_walk;
        wr_busy [*2] ##1 !wr_busy;
    endsequence

    // Write lengths and held inputs
    a_plain_write_len: assert property (
        $rose(wren) && (!mask_en || erase) |-> plain_walk) else $error("plain write or delete length wrong");
    a_mask_write_len: assert property (
        $rose(wren) && mask_en && !erase |-> mask_walk) else $error("masked write length wrong");
    a_write_hold: assert property (
        wr_busy |=> wren && $stable(wr_idx) && $stable(key) && $stable(mask_en)) else $error("write inputs moved");
    a_busy_has_wren: assert property (
        wr_busy |-> wren) else $error("write busy without write request");

    // Search results and idle request lines in single mode
    a_single_count: assert property (
        hit_count == {{($clog2(ENTRY_COUNT+1)-1){1'h0}}, hit}) else $error("hit count not zero or one");
    a_hit_vector: assert property (
        hit == (|match_vec)) else $error("hit flag disagrees with vector");
    a_index_bit: assert property (
        hit |-> match_vec[match_idx] && (match_idx < ENTRY_COUNT)) else $error("match index not in vector");
    a_no_step_req: assert property (
        !first_req && !next_req && !rd_busy) else $error("stepping activity in single mode");
endmodule
`default_nettype wire

// ==== test/content_addressable_memory_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module content_addressable_memory_test;
    import cam_pkg::*;
    logic clk;
    logic rst_n;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest;
    logic out_rst_n;
    logic out_clk_en;
    int n_errors = 0;
    int comparisons = 0;

    // Host and array joined across the link, checker beside it
    cam_if #(.ENTRY_COUNT(6)) link_if ();
    cam_host #(.ENTRY_COUNT(6)) u_cam_host (.link(link_if), .clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    cam_array #(.ENTRY_COUNT(6), .OUT_REG(1'h1)) u_cam_array (.link(link_if), .clk(clk), .rst_n(rst_n),
        .out_rst_n(out_rst_n), .out_clk_en(out_clk_en));
    cam_link_props u_cam_link_props (.clk(clk), .rst_n(rst_n),
        .key(link_if.key), .mask_en(link_if.mask_en), .erase(link_if.erase), .wren(link_if.wren),
        .wr_idx(link_if.wr_idx), .first_req(link_if.first_req), .next_req(link_if.next_req),
        .hit(link_if.hit), .match_idx(link_if.match_idx), .match_vec(link_if.match_vec),
        .hit_count(link_if.hit_count), .rd_busy(link_if.rd_busy), .wr_busy(link_if.wr_busy));

    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; request held until a rising edge sees waitrequest low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 200);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        if (avs_waitrequest !== 1'h0) begin
            n_errors++;
            final_report();
        end
    endtask

    // Polling status, since key writes are dropped while busy
    task automatic put(input logic [2:0] idx, input logic [7:0] k, input logic [7:0] m, input logic [2:0] cmd);
        int n = 0;
        bus(1'h1, OFS_KEY, {24'h0, k}, rd);
        bus(1'h1, OFS_MASK, {24'h0, m}, rd);
        bus(1'h1, OFS_INDEX, {29'h0, idx}, rd);
        bus(1'h1, OFS_CMD, {29'h0, cmd}, rd);
        do begin
            bus(1'h0, OFS_STATUS, 32'h0, rd);
            n++;
        end while (rd[ST_BUSY_BIT] !== 1'h0 && n < 50);
        if (n >= 50) begin
            n_errors++;
            final_report();
        end
    endtask

    // Single mode searches continuously; index is left open on a miss
    task automatic look(input logic [7:0] k, input logic h, input logic [2:0] idx);
        logic [31:0] st;
        bus(1'h1, OFS_KEY, {24'h0, k}, rd);
        bus(1'h0, OFS_STATUS, 32'h0, st);
        check("status", h ? ({29'h0, idx} << 16) | 32'h102 : 32'h0, h ? st : st & 32'h0000ffff);
        bus(1'h0, OFS_MATCH, 32'h0, rd);
        check("match vector", h ? 32'h1 << idx : 32'h0, rd);
    endtask

    task automatic t_reset();
        bus(1'h0, OFS_KEY, 32'h0, rd);
        check("key reset", KEY_RESET, rd);
        bus(1'h0, OFS_MASK, 32'h0, rd);
        check("mask reset", MASK_RESET, rd);
        bus(1'h0, 5'h18, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        look(8'h00, 1'h0, 3'h0);
    endtask

    task automatic t_write();
        put(3'h2, 8'h5a, 8'h0f, 3'h1);
        look(8'h5a, 1'h1, 3'h2);
        look(8'h5b, 1'h0, 3'h0);
    endtask

    task automatic t_mask();
        put(3'h5, 8'h30, 8'h0f, 3'h5);
        look(8'h3c, 1'h1, 3'h5);
        look(8'h70, 1'h0, 3'h0);
    endtask

    task automatic t_never();
        put(3'h0, 8'h01, 8'h01, 3'h5);
        look(8'h01, 1'h0, 3'h0);
        look(8'h00, 1'h0, 3'h0);
    endtask

    task automatic t_delete();
        put(3'h5, 8'h3c, 8'h00, 3'h7);
        look(8'h3c, 1'h0, 3'h0);
        look(8'h5a, 1'h1, 3'h2);
    endtask

    // Output stage freezes without its enable and clears on its own reset
    task automatic t_out_stage();
        look(8'h5a, 1'h1, 3'h2);
        @(posedge clk);
        out_clk_en <= 1'h0;
        bus(1'h1, OFS_KEY, 32'h3c, rd);
        bus(1'h0, OFS_STATUS, 32'h0, rd);
        check("frozen status", 32'h0002_0102, rd);
        @(posedge clk);
        out_rst_n <= 1'h0;
        bus(1'h0, OFS_STATUS, 32'h0, rd);
        check("cleared status", 32'h0, rd);
        @(posedge clk);
        out_rst_n <= 1'h1;
        out_clk_en <= 1'h1;
        look(8'h5a, 1'h1, 3'h2);
    endtask

    // Clock at 50 MHz
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Reset for ten cycles, then the scenarios
    initial begin
        rst_n = 1'h0;
        out_rst_n = 1'h0;
        out_clk_en = 1'h1;
        avs_address = 5'h0;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        out_rst_n <= 1'h1;
        t_reset();
        t_write();
        t_mask();
        t_never();
        t_delete();
        t_out_stage();
        final_report();
    end
endmodule
`default_nettype wire
